// ---- rtl/spm_shared_pin_mux.sv ----
// Purpose: per-pin choice between general-purpose port and alternate function
// Assumes: pad inputs are asynchronous; peripheral and gpio signals share clock
// Notes:   every output is registered, so a selection change shows one cycle later
//
// Summary of operation
// - port zero is low data byte with bus
// - port one is high data byte, 16-bit bus
// - port two drives address bits 0..7 with bus
// - port three drives address 8..15 when selected
// - port four low three drive address 16..18
// - port four upper five drive address 19..23
// - port four upper pins feed enabled reload timers
// - interrupt inputs sampled whenever enabled
// - clock pin drives machine clock with bus and enable
// - ready input used only with bus and enable
// - hold request in, acknowledge out with bus and enable
// - hold request sampled every cycle, only with bus and enable
// - upper write strobe needs bus, 16-bit, enable
// - lower write strobe needs bus and enable
// - read strobe driven whenever bus enabled
// - write-block input always sampled, port stays
// - ports six, nine analog or open-drain per pin
// - port seven carries compare outputs per enable
// - port eight low six carry timer outputs
// - port eight top two carry pulse generators
// - port A width inputs and outputs per channel
// - port A capture inputs routed, port valid
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ns

module spm_shared_pin_mux
    import spm_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // port logic side
    input  wire spm_pkg::spm_pad_t    gpioOut,
    input  wire spm_pkg::spm_pad_t    gpioDir,
    // peripheral side
    input  wire spm_pkg::spm_periph_s periphIn,
    output spm_pkg::spm_core_s        coreOut,
    // pad side
    input  wire spm_pkg::spm_pad_t    padIn,
    output spm_pkg::spm_pad_t         padOut,
    output spm_pkg::spm_pad_t         padOe
);
    import spm_pkg::*;

    typedef struct packed {
        logic [9:0]  ctrl;
        logic [15:0] analogEn;
        logic [7:0]  compareEn;
        logic [12:0] timerEn;
        logic [15:0] pulseEn;
        logic [7:0]  irqEn;
        spm_pad_t    sync1;
        spm_pad_t    sync2;
        spm_pad_t    padOut;
        spm_pad_t    padOe;
        spm_core_s   core;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } spm_state_s;

    spm_state_s st_reg;
    spm_state_s st_next;

    // reads of a register word; unmapped offsets give zero and an error
    function automatic logic [32:0] spm_read(input spm_state_s s, input logic [7:0] a);
        logic [32:0] r;
        r = {1'b0, 32'h00000000};
        unique case (a)
            SPM_CTRL_OFS:   r[9:0]  = s.ctrl;
            SPM_ANALOG_OFS: r[15:0] = s.analogEn;
            SPM_CMP_OFS:    r[7:0]  = s.compareEn;
            SPM_TIMER_OFS:  r[12:0] = s.timerEn;
            SPM_PULSE_OFS:  r[15:0] = s.pulseEn;
            SPM_IRQ_OFS:    r[7:0]  = s.irqEn;
            SPM_STATUS_OFS: r[7:0]  = s.sync2[SPM_P5];
            default:        r[32]   = 1'b1;
        endcase
        return r;
    endfunction

    // one alternate output on one pin: the function wins over the port
    function automatic logic [1:0] spm_alt(input logic sel, input logic val,
                                           input logic pOut, input logic pDir);
        return sel ? {1'b1, val} : {pDir, pOut};
    endfunction

    always_comb begin
        logic        extBus;
        logic        bus16;
        logic        wrAccess;
        logic [32:0] rd;
        logic [1:0]  pin;
        st_next  = st_reg;
        extBus   = st_reg.ctrl[SPM_CTRL_EXTBUS];
        bus16    = st_reg.ctrl[SPM_CTRL_BUS16];
        wrAccess = psel && penable && st_reg.pready && pwrite;
        rd       = spm_read(st_reg, paddr);
        pin      = 2'b00;

        // zero-wait apb: answer is prepared in the setup cycle
        st_next.pready  = psel && !penable;
        st_next.prdata  = (psel && !penable && !pwrite) ? rd[31:0] : 32'h00000000;
        // status is read-only, so a write to it is refused like an unmapped one
        st_next.pslverr = psel && !penable && (rd[32] || (pwrite && paddr == SPM_STATUS_OFS));

        // register writes take effect only at the completing edge
        if (wrAccess) begin
            unique case (paddr)
                SPM_CTRL_OFS:   st_next.ctrl      = pwdata[9:0];
                SPM_ANALOG_OFS: st_next.analogEn  = pwdata[15:0];
                SPM_CMP_OFS:    st_next.compareEn = pwdata[7:0];
                SPM_TIMER_OFS:  st_next.timerEn   = pwdata[12:0];
                SPM_PULSE_OFS:  st_next.pulseEn   = pwdata[15:0];
                SPM_IRQ_OFS:    st_next.irqEn     = pwdata[7:0];
                default:        st_next.ctrl      = st_reg.ctrl;
            endcase
        end

        // pads pass two flops; only the second stage is read below
        st_next.sync1      = padIn;
        st_next.sync2      = st_reg.sync1;
        st_next.core.gpioIn = st_reg.sync2;

        // default: every pin follows the port logic
        st_next.padOut = gpioOut;
        st_next.padOe  = gpioDir;

        // external bus data and address
        for (int i = 0; i < 8; i++) begin
            pin = spm_alt(extBus, periphIn.busDataOut[i],
                          gpioOut[SPM_P0][i], gpioDir[SPM_P0][i]);
            st_next.padOut[SPM_P0][i] = pin[0];
            st_next.padOe[SPM_P0][i]  = extBus ? periphIn.busDataOe : pin[1];
            pin = spm_alt(extBus && bus16, periphIn.busDataOut[i + 8],
                          gpioOut[SPM_P1][i], gpioDir[SPM_P1][i]);
            st_next.padOut[SPM_P1][i] = pin[0];
            st_next.padOe[SPM_P1][i]  = (extBus && bus16) ? periphIn.busDataOe
                                                         : pin[1];
            pin = spm_alt(extBus, periphIn.address[i],
                          gpioOut[SPM_P2][i], gpioDir[SPM_P2][i]);
            {st_next.padOe[SPM_P2][i], st_next.padOut[SPM_P2][i]} = pin;
            pin = spm_alt(extBus && st_reg.ctrl[SPM_CTRL_MIDADR], periphIn.address[i + 8],
                          gpioOut[SPM_P3][i], gpioDir[SPM_P3][i]);
            {st_next.padOe[SPM_P3][i], st_next.padOut[SPM_P3][i]} = pin;
        end
        for (int i = 0; i < 3; i++) begin
            pin = spm_alt(extBus && st_reg.ctrl[SPM_CTRL_HIGHADR], periphIn.address[i + 16],
                          gpioOut[SPM_P4][i], gpioDir[SPM_P4][i]);
            {st_next.padOe[SPM_P4][i], st_next.padOut[SPM_P4][i]} = pin;
        end
        for (int i = 3; i < 8; i++) begin
            pin = spm_alt(extBus && st_reg.ctrl[SPM_CTRL_TOPADR], periphIn.address[i + 16],
                          gpioOut[SPM_P4][i], gpioDir[SPM_P4][i]);
            {st_next.padOe[SPM_P4][i], st_next.padOut[SPM_P4][i]} = pin;
        end

        // bus data read back; upper byte is zero on an 8-bit bus
        st_next.core.busDataIn[7:0]  = extBus ? st_reg.sync2[SPM_P0] : 8'h00;
        st_next.core.busDataIn[15:8] = (extBus && bus16) ? st_reg.sync2[SPM_P1]
                                                         : 8'h00;

        // port five: bus control pins
        pin = spm_alt(extBus && st_reg.ctrl[SPM_CTRL_CLKOUT], periphIn.machineClk,
                      gpioOut[SPM_P5][SPM_P5_CLK], gpioDir[SPM_P5][SPM_P5_CLK]);
        {st_next.padOe[SPM_P5][SPM_P5_CLK], st_next.padOut[SPM_P5][SPM_P5_CLK]} = pin;
        pin = spm_alt(extBus && st_reg.ctrl[SPM_CTRL_HOLD], periphIn.holdAcknowledge,
                      gpioOut[SPM_P5][SPM_P5_HAK], gpioDir[SPM_P5][SPM_P5_HAK]);
        {st_next.padOe[SPM_P5][SPM_P5_HAK], st_next.padOut[SPM_P5][SPM_P5_HAK]} = pin;
        pin = spm_alt(extBus && bus16 && st_reg.ctrl[SPM_CTRL_WRHIGH],
                      periphIn.upperWriteStrobe,
                      gpioOut[SPM_P5][SPM_P5_WRH], gpioDir[SPM_P5][SPM_P5_WRH]);
        {st_next.padOe[SPM_P5][SPM_P5_WRH], st_next.padOut[SPM_P5][SPM_P5_WRH]} = pin;
        pin = spm_alt(extBus && st_reg.ctrl[SPM_CTRL_WRLOW], periphIn.lowerWriteStrobe,
                      gpioOut[SPM_P5][SPM_P5_WRL], gpioDir[SPM_P5][SPM_P5_WRL]);
        {st_next.padOe[SPM_P5][SPM_P5_WRL], st_next.padOut[SPM_P5][SPM_P5_WRL]} = pin;
        pin = spm_alt(extBus, periphIn.readStrobe,
                      gpioOut[SPM_P5][SPM_P5_RD], gpioDir[SPM_P5][SPM_P5_RD]);
        {st_next.padOe[SPM_P5][SPM_P5_RD], st_next.padOut[SPM_P5][SPM_P5_RD]} = pin;

        // ready defaults high so a disabled pin never stretches a bus cycle
        st_next.core.readyIn = (extBus && st_reg.ctrl[SPM_CTRL_READY])
                               ? st_reg.sync2[SPM_P5][SPM_P5_READY] : 1'b1;
        // hold request is live on every cycle while the function is on
        st_next.core.holdRequestIn = extBus && st_reg.ctrl[SPM_CTRL_HOLD]
                                     && st_reg.sync2[SPM_P5][SPM_P5_HRQ];
        // write-block request is sampled in every mode
        st_next.core.ramWriteBlockIn = st_reg.sync2[SPM_P5][SPM_P5_WBLK];

        // reload timer inputs on the upper port four pins
        st_next.core.reloadTimerInputs = st_reg.sync2[SPM_P4][7:3]
                                         & st_reg.timerEn[SPM_TIMER_IN_LSB +: 5];

        // interrupt inputs: bits 1..0 and 2 on port A, 7..3 on port four
        st_next.core.extIrqInputs = {st_reg.sync2[SPM_P4][7:3], st_reg.sync2[SPM_PA][7],
                                     st_reg.sync2[SPM_PA][6:5]} & st_reg.irqEn;

        // analog pins are open drain: only pull low, never while analog
        for (int i = 0; i < 8; i++) begin
            st_next.padOut[SPM_P6][i] = 1'b0;
            st_next.padOe[SPM_P6][i]  = gpioDir[SPM_P6][i] && !gpioOut[SPM_P6][i]
                                        && !st_reg.analogEn[i];
            st_next.padOut[SPM_P9][i] = 1'b0;
            st_next.padOe[SPM_P9][i]  = gpioDir[SPM_P9][i] && !gpioOut[SPM_P9][i]
                                        && !st_reg.analogEn[i + 8];
        end
        st_next.core.analogInputEnable = st_reg.analogEn;

        // compare, reload timer and pulse generator outputs
        for (int i = 0; i < 8; i++) begin
            pin = spm_alt(st_reg.compareEn[i], periphIn.compareOutputs[i],
                          gpioOut[SPM_P7][i], gpioDir[SPM_P7][i]);
            {st_next.padOe[SPM_P7][i], st_next.padOut[SPM_P7][i]} = pin;
        end
        for (int i = 0; i < 6; i++) begin
            pin = spm_alt(st_reg.timerEn[i], periphIn.reloadTimerOutputs[i],
                          gpioOut[SPM_P8][i], gpioDir[SPM_P8][i]);
            {st_next.padOe[SPM_P8][i], st_next.padOut[SPM_P8][i]} = pin;
        end
        for (int i = 0; i < 2; i++) begin
            pin = spm_alt(st_reg.pulseEn[i], periphIn.pulseGenOutputs[i],
                          gpioOut[SPM_P8][i + 6], gpioDir[SPM_P8][i + 6]);
            {st_next.padOe[SPM_P8][i + 6], st_next.padOut[SPM_P8][i + 6]} = pin;
        end

        // port A: width unit on pins 1..4, capture on pins 0 and 2..4
        for (int i = 0; i < 4; i++) begin
            pin = spm_alt(st_reg.pulseEn[SPM_PULSE_POT_LSB + i], periphIn.widthUnitOutputs[i],
                          gpioOut[SPM_PA][i + 1], gpioDir[SPM_PA][i + 1]);
            {st_next.padOe[SPM_PA][i + 1], st_next.padOut[SPM_PA][i + 1]} = pin;
        end
        st_next.core.widthMeasureInputs = st_reg.sync2[SPM_PA][4:1]
                                          & st_reg.pulseEn[SPM_PULSE_PWC_LSB +: 4];
        st_next.core.captureInputs = {st_reg.sync2[SPM_PA][4:2], st_reg.sync2[SPM_PA][0]}
                                     & st_reg.pulseEn[SPM_PULSE_CAP_LSB +: 4];
    end

    // single state register; reset leaves every pin a released input
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_reg           <= '0;
            st_reg.ctrl      <= SPM_CTRL_RST;
            st_reg.analogEn  <= SPM_ANALOG_RST;
            st_reg.compareEn <= SPM_BYTE_RST;
            st_reg.irqEn     <= SPM_BYTE_RST;
            st_reg.core.readyIn <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata  = st_reg.prdata;
    assign pready  = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign coreOut = st_reg.core;
    assign padOut  = st_reg.padOut;
    assign padOe   = st_reg.padOe;

endmodule

// ---- rtl/spm_pkg.sv ----
// Purpose: shared constants and carrier types of the shared pin function select block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   pads are grouped as eleven 8-bit ports, index 0 to 10 (10 = port A)
package spm_pkg;

    // register byte offsets
    localparam logic [7:0] SPM_CTRL_OFS   = 8'h00;
    localparam logic [7:0] SPM_ANALOG_OFS = 8'h04;
    localparam logic [7:0] SPM_CMP_OFS    = 8'h08;
    localparam logic [7:0] SPM_TIMER_OFS  = 8'h0c;
    localparam logic [7:0] SPM_PULSE_OFS  = 8'h10;
    localparam logic [7:0] SPM_IRQ_OFS    = 8'h14;
    localparam logic [7:0] SPM_STATUS_OFS = 8'h18;

    // control register bit positions
    localparam int SPM_CTRL_EXTBUS  = 0;
    localparam int SPM_CTRL_BUS16   = 1;
    localparam int SPM_CTRL_MIDADR  = 2;
    localparam int SPM_CTRL_HIGHADR = 3;
    localparam int SPM_CTRL_TOPADR  = 4;
    localparam int SPM_CTRL_CLKOUT  = 5;
    localparam int SPM_CTRL_READY   = 6;
    localparam int SPM_CTRL_HOLD    = 7;
    localparam int SPM_CTRL_WRHIGH  = 8;
    localparam int SPM_CTRL_WRLOW   = 9;

    // timer register fields: outputs in 5:0, inputs (channels 1..5) in 12:8
    localparam int SPM_TIMER_IN_LSB = 8;
    // pulse register fields
    localparam int SPM_PULSE_POT_LSB = 4;
    localparam int SPM_PULSE_PWC_LSB = 8;
    localparam int SPM_PULSE_CAP_LSB = 12;

    // values after reset: single-chip, every pin a port
    localparam logic [9:0]  SPM_CTRL_RST   = 10'h000;
    localparam logic [15:0] SPM_ANALOG_RST = 16'h0000;
    localparam logic [7:0]  SPM_BYTE_RST   = 8'h00;

    // port indices
    localparam int SPM_P0 = 0;
    localparam int SPM_P1 = 1;
    localparam int SPM_P2 = 2;
    localparam int SPM_P3 = 3;
    localparam int SPM_P4 = 4;
    localparam int SPM_P5 = 5;
    localparam int SPM_P6 = 6;
    localparam int SPM_P7 = 7;
    localparam int SPM_P8 = 8;
    localparam int SPM_P9 = 9;
    localparam int SPM_PA = 10;

    // port five pin positions
    localparam int SPM_P5_CLK   = 0;
    localparam int SPM_P5_READY = 1;
    localparam int SPM_P5_HAK   = 2;
    localparam int SPM_P5_HRQ   = 3;
    localparam int SPM_P5_WRH   = 4;
    localparam int SPM_P5_WRL   = 5;
    localparam int SPM_P5_RD    = 6;
    localparam int SPM_P5_WBLK  = 7;

    typedef logic [10:0][7:0] spm_pad_t;

    // signals from the on-chip bus controller and peripherals
    typedef struct packed {
        logic [15:0] busDataOut;
        logic        busDataOe;
        logic [23:0] address;
        logic        readStrobe;
        logic        lowerWriteStrobe;
        logic        upperWriteStrobe;
        logic        machineClk;
        logic        holdAcknowledge;
        logic [7:0]  compareOutputs;
        logic [5:0]  reloadTimerOutputs;
        logic [1:0]  pulseGenOutputs;
        logic [3:0]  widthUnitOutputs;
    } spm_periph_s;

    // signals handed to the core and peripherals
    typedef struct packed {
        logic [15:0] busDataIn;
        logic        readyIn;
        logic        holdRequestIn;
        logic        ramWriteBlockIn;
        logic [4:0]  reloadTimerInputs;
        logic [7:0]  extIrqInputs;
        logic [3:0]  widthMeasureInputs;
        logic [3:0]  captureInputs;
        logic [15:0] analogInputEnable;
        spm_pad_t    gpioIn;
    } spm_core_s;

endpackage

// ---- verification/spm_board_model.sv ----
// Purpose: board side of the pads, sources and pull-ups
// Assumes: wherever the mux enables a pad, the board only listens
// Notes:   ports six and nine are open drain, pulled up on the board
`timescale 1ns/1ns

module spm_board_model (
    input  wire spm_pkg::spm_pad_t padOut,
    input  wire spm_pkg::spm_pad_t padOe,
    input  wire spm_pkg::spm_pad_t srcLevel,
    output spm_pkg::spm_pad_t      padIn
);
    import spm_pkg::*;

    // sources back off on every pad the mux drives
    always_comb begin
        padIn = (padOe & padOut) | (~padOe & srcLevel);
        // open drain: a driven pad pulls low, a released one floats up
        padIn[SPM_P6] = ~padOe[SPM_P6] & srcLevel[SPM_P6];
        padIn[SPM_P9] = ~padOe[SPM_P9] & srcLevel[SPM_P9];
    end
endmodule

// ---- verification/spm_shared_pin_mux_monitor.sv ----
// Purpose: port-level checks of the pin function choice
// Assumes: selection registers are shadowed from completed apb writes
// Notes:   pad outputs are registered, hence the one-cycle offsets
`timescale 1ns/1ns

module spm_mux_monitor (
    input wire logic                 clock,
    input wire logic                 arst_n,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire spm_pkg::spm_pad_t    gpioOut,
    input wire spm_pkg::spm_pad_t    gpioDir,
    input wire spm_pkg::spm_periph_s periphIn,
    input wire spm_pkg::spm_core_s   coreOut,
    input wire spm_pkg::spm_pad_t    padIn,
    input wire spm_pkg::spm_pad_t    padOut,
    input wire spm_pkg::spm_pad_t    padOe
);
    import spm_pkg::*;

    logic [9:0]  ctrlReg;
    logic [15:0] analogReg;
    logic [7:0]  cmpReg;
    logic [1:0]  upCnt;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n || upCnt == 2'd0);

    // shadow registers; upCnt keeps $past away from reset values
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrlReg   <= '0;
            analogReg <= '0;
            cmpReg    <= '0;
            upCnt     <= '0;
        end else begin
            upCnt <= (upCnt == 2'd3) ? upCnt : upCnt + 2'd1;
            if (psel && penable && pready && pwrite) begin
                case (paddr)
                    SPM_CTRL_OFS:   ctrlReg   <= pwdata[9:0];
                    SPM_ANALOG_OFS: analogReg <= pwdata[15:0];
                    SPM_CMP_OFS:    cmpReg    <= pwdata[7:0];
                    default:        ;
                endcase
            end
        end
    end

    sequence setupPhase;
        psel && !penable;
    endsequence

    apb_answer_a: assert property (setupPhase |=> pready)
        else $error("no answer in the access cycle");
    p0_data_a: assert property (
        ctrlReg[SPM_CTRL_EXTBUS] |=> padOut[SPM_P0] == $past(periphIn.busDataOut[7:0])
        && padOe[SPM_P0] == {8{$past(periphIn.busDataOe)}}) else $error("port zero not data");
    p1_port_a: assert property (
        !(ctrlReg[SPM_CTRL_EXTBUS] && ctrlReg[SPM_CTRL_BUS16]) |=> padOut[SPM_P1] ==
        $past(gpioOut[SPM_P1]) && padOe[SPM_P1] == $past(gpioDir[SPM_P1])) else $error("port one");
    p2_addr_a: assert property (ctrlReg[SPM_CTRL_EXTBUS] |=>
        padOut[SPM_P2] == $past(periphIn.address[7:0]) && padOe[SPM_P2] == 8'hff)
        else $error("port two not address");
    p3_mid_a: assert property (ctrlReg[SPM_CTRL_EXTBUS] && ctrlReg[SPM_CTRL_MIDADR] |=>
        padOut[SPM_P3] == $past(periphIn.address[15:8])) else $error("port three not address");
    clk_out_a: assert property (ctrlReg[SPM_CTRL_EXTBUS] && ctrlReg[SPM_CTRL_CLKOUT] |=>
        padOut[SPM_P5][SPM_P5_CLK] == $past(periphIn.machineClk) && padOe[SPM_P5][SPM_P5_CLK])
        else $error("clock pin not driven");
    rd_strobe_a: assert property (ctrlReg[SPM_CTRL_EXTBUS] |=>
        padOut[SPM_P5][SPM_P5_RD] == $past(periphIn.readStrobe)) else $error("read strobe");
    wrh_off_a: assert property (!ctrlReg[SPM_CTRL_BUS16] |=>
        padOe[SPM_P5][SPM_P5_WRH] == $past(gpioDir[SPM_P5][SPM_P5_WRH])) else $error("upper strobe");
    cmp_pick_a: assert property (1'b1 |=> padOut[SPM_P7] ==
        $past((cmpReg & periphIn.compareOutputs) | (~cmpReg & gpioOut[SPM_P7])))
        else $error("compare pins wrong");
    drain_pins_a: assert property (upCnt != 2'd0 |-> padOut[SPM_P6] == 8'h00 &&
        padOe[SPM_P6] == $past(gpioDir[SPM_P6] & ~gpioOut[SPM_P6] & ~analogReg[7:0]))
        else $error("open drain port six wrong");
    wblk_sync_a: assert property (upCnt == 2'd3 |->
        coreOut.ramWriteBlockIn == $past(padIn[SPM_P5][SPM_P5_WBLK], 3)) else $error("write block");
endmodule

bind spm_shared_pin_mux spm_mux_monitor i_mon (.clock, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .gpioOut, .gpioDir, .periphIn, .coreOut, .padIn, .padOut, .padOe);

// ---- verification/tb_spm_shared_pin_mux.sv ----
// Purpose: directed bench for the shared pin function select
// Assumes: zero-wait apb slave, registered pads, three-edge input sync
// Notes:   one idle cycle between apb transfers keeps drives single
`timescale 1ns/1ns

module tb_spm_shared_pin_mux;
    import spm_pkg::*;

    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    spm_pad_t    gpioOut, gpioDir, src, padIn, padOut, padOe;
    spm_periph_s periphIn;
    spm_core_s   coreOut;
    int          miscompares = 0;
    int          comparisons = 0;

    spm_shared_pin_mux i_dut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .gpioOut, .gpioDir, .periphIn, .coreOut, .padIn,
        .padOut, .padOe);
    spm_board_model i_board (.padOut, .padOe, .srcLevel(src), .padIn);

    always #5 clock = ~clock;

    task automatic chk(input string what, input logic [87:0] seen, input logic [87:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] expD);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk("read data", r, expD);
        chk("read error", e, 1'b0);
    endtask

    task automatic t_reset;
        chk("pad enables", padOe, '0);
        chk("ready idle", coreOut.readyIn, 1'b1);
        rd(SPM_CTRL_OFS, 32'h0);
    endtask

    task automatic t_single;
        tick(4);
        chk("port zero gpio", padOut[SPM_P0], gpioOut[SPM_P0]);
        chk("port two gpio", padOut[SPM_P2], gpioOut[SPM_P2]);
        chk("port five oe", padOe[SPM_P5], gpioDir[SPM_P5]);
        chk("write block", coreOut.ramWriteBlockIn, src[SPM_P5][SPM_P5_WBLK]);
    endtask

    // 8-bit bus: mid address and both strobe enables, upper strobe must stay port
    task automatic t_bus8;
        wr(SPM_CTRL_OFS, 32'h305);
        tick(2);
        chk("low data", padOut[SPM_P0], periphIn.busDataOut[7:0]);
        chk("port one", padOut[SPM_P1], gpioOut[SPM_P1]);
        chk("addr low", padOut[SPM_P2], periphIn.address[7:0]);
        chk("addr mid", padOut[SPM_P3], periphIn.address[15:8]);
        chk("port four", padOut[SPM_P4], gpioOut[SPM_P4]);
        chk("upper strobe", padOut[SPM_P5][SPM_P5_WRH], gpioOut[SPM_P5][SPM_P5_WRH]);
        chk("lower strobe", padOut[SPM_P5][SPM_P5_WRL], periphIn.lowerWriteStrobe);
        chk("read strobe", padOut[SPM_P5][SPM_P5_RD], periphIn.readStrobe);
    endtask

    task automatic t_bus16;
        wr(SPM_CTRL_OFS, 32'h3ff);
        src[SPM_P5][SPM_P5_HRQ] <= 1'b1;
        tick(5);
        chk("high data", padOut[SPM_P1], periphIn.busDataOut[15:8]);
        chk("addr high", padOut[SPM_P4], periphIn.address[23:16]);
        chk("bus pins", {padOut[SPM_P5][6:4], padOut[SPM_P5][2], padOut[SPM_P5][0]},
            {periphIn.readStrobe, periphIn.lowerWriteStrobe, periphIn.upperWriteStrobe,
             periphIn.holdAcknowledge, periphIn.machineClk});
        chk("ready in", coreOut.readyIn, 1'b0);
        chk("hold request", coreOut.holdRequestIn, 1'b1);
        chk("bus data in", coreOut.busDataIn, periphIn.busDataOut);
    endtask

    // single chip again, compare pins 3..0 and the timer, pulse, width output, capture and irq functions switched on
    task automatic t_periph;
        wr(SPM_CTRL_OFS, 32'h0);
        wr(SPM_CMP_OFS, 32'h0f);
        wr(SPM_TIMER_OFS, 32'h1f3f);
        wr(SPM_PULSE_OFS, 32'hf0f3);
        wr(SPM_IRQ_OFS, 32'hff);
        tick(5);
        chk("compare", padOut[SPM_P7], {gpioOut[SPM_P7][7:4], periphIn.compareOutputs[3:0]});
        chk("timer out", padOut[SPM_P8], {periphIn.pulseGenOutputs, periphIn.reloadTimerOutputs});
        chk("width out", padOut[SPM_PA][4:1], periphIn.widthUnitOutputs);
        chk("timer in", coreOut.reloadTimerInputs, src[SPM_P4][7:3]);
        chk("irq in", coreOut.extIrqInputs, {src[SPM_P4][7:3], src[SPM_PA][7:5]});
        chk("capture", coreOut.captureInputs, {periphIn.widthUnitOutputs[3:1], src[SPM_PA][0]});
        wr(SPM_PULSE_OFS, 32'h0f00);
        tick(5);
        chk("width in", coreOut.widthMeasureInputs, src[SPM_PA][4:1]);
        chk("port a view", coreOut.gpioIn[SPM_PA], src[SPM_PA]);
    endtask

    task automatic t_analog;
        wr(SPM_ANALOG_OFS, 32'h0ff0);
        tick(2);
        chk("drain six", padOe[SPM_P6], gpioDir[SPM_P6] & ~gpioOut[SPM_P6] & 8'h0f);
        chk("drain nine", padOe[SPM_P9], gpioDir[SPM_P9] & ~gpioOut[SPM_P9] & 8'hf0);
        chk("analog enable", coreOut.analogInputEnable, 16'h0ff0);
    endtask

    // refused writes and unused upper bits
    task automatic t_apb;
        logic [31:0] r;
        logic        e;
        apb(1'b1, 8'h1c, 32'h1, r, e);
        chk("unmapped error", e, 1'b1);
        apb(1'b1, SPM_STATUS_OFS, 32'hff, r, e);
        chk("status error", e, 1'b1);
        wr(SPM_CTRL_OFS, 32'hffff_ffff);
        rd(SPM_CTRL_OFS, 32'h3ff);
        rd(SPM_STATUS_OFS, 32'ha8);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // every port gets a distinct gpio pattern so a wrong pick shows
    initial begin
        for (int i = 0; i < 11; i++) begin
            gpioOut[i] = 8'h5a ^ 8'(i);
        end
        gpioDir = {11{8'hff}};
        gpioDir[SPM_P4] = 8'h07;
        gpioDir[SPM_P5] = 8'h71;
        gpioDir[SPM_PA] = 8'h00;
        src = {11{8'hff}};
        src[SPM_P4] = 8'hb8;
        src[SPM_P5] = 8'h80;
        src[SPM_PA] = 8'hb5;
        periphIn = '{16'hc33c, 1'b1, 24'h8a5c3e, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h96, 6'h2d,
                     2'b10, 4'h9};
        tick(10);
        arst_n <= 1'b1;
        tick(1);
        t_reset();
        t_single();
        t_bus8();
        t_bus16();
        t_periph();
        t_analog();
        t_apb();
        report_and_stop();
    end

    // hang guard: the run needs a few hundred cycles at most
    initial begin
        tick(3000);
        miscompares++;
        report_and_stop();
    end
endmodule
